// ==== bench/nand_flash_model.sv ====
// Behavioural page flash that answers the host's command, address and data pins
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_defines.svh"
module nand_flash_model
   import nand_host_pkg::*;
(
   input  wire logic     x16,
   input  wire pinsOut_s pins,
   output var  pinsIn_s  pinsIn
);
   logic [7:0]  cmdLog[$];
   logic [7:0]  addrLog[$];
   logic [15:0] dataLog[$];
   int          upperHigh;
   int          ceViolations;
   int          need;
   logic [9:0]  col;
   logic [15:0] lastOut;
   logic [15:0] page;
   logic [7:0]  cmd;
   logic        busy;
   logic        halfSel;
   logic        spare;
   logic        goBusy;
   logic        weArmed = 1'b0;
   wire  logic  weN = pins.weN;
   wire  logic  rdN = pins.read_strobe_n;

   initial begin
      {upperHigh, ceViolations, need} = '0;
      {col, lastOut, page, cmd, busy, halfSel, spare, goBusy} = '0;
   end

   function automatic logic [15:0] pattern(input logic [9:0] c);
      pattern = {~c[7:0], c[7:0] ^ {c[9:8], c[9:8], 4'hc}};
   endfunction : pattern

   always @(goBusy) begin
      busy = 1'b1;
      #1000;
      busy = 1'b0;
   end

   // The x-to-1 step of the strobe at reset is no write cycle
   always @(negedge weN) weArmed = 1'b1;

   always @(posedge weN) begin
      if (pins.ceN && weArmed) ceViolations++;
      if (pins.ioOut[15:8] != 8'h00 && (pins.cle || pins.ale)) upperHigh++;
      if (pins.cle && (!busy || pins.ioOut[7:0] inside {8'hff, 8'h70})) begin
         cmd = pins.ioOut[7:0];
         cmdLog.push_back(cmd);
         need = (cmd inside {8'h00, 8'h01, 8'h50, 8'h80, 8'h8a}) ? 3 :
                (cmd == 8'h60) ? 2 : (cmd == 8'h90) ? 1 : 0;
         if (cmd inside {8'h00, 8'h01, 8'h50}) halfSel = (cmd == 8'h01);
         if (cmd inside {8'h00, 8'h01, 8'h50}) spare = (cmd == 8'h50);
         if (cmd inside {8'h10, 8'hd0}) goBusy = ~goBusy;
      end else if (pins.ale && need > 0) begin
         addrLog.push_back(pins.ioOut[7:0]);
         if (need == 3 && spare)
            col = (x16 ? 10'd256 : 10'd512) + {6'h0, pins.ioOut[3:0]};
         else if (need == 3)
            col = {1'b0, halfSel, pins.ioOut[7:0]};
         else
            page = {pins.ioOut[7:0], page[15:8]};
         need--;
         if (need == 0 && cmd inside {8'h00, 8'h01, 8'h50, 8'h8a}) goBusy = ~goBusy;
      end else if (!pins.cle && !pins.ale) begin
         dataLog.push_back(x16 ? pins.ioOut : {8'h00, pins.ioOut[7:0]});
      end
   end

   always @(negedge rdN) begin
      if (!pins.ceN) begin
         lastOut = pattern(col);
         col = col + 10'd1;
      end
   end

   // Released bus shows the inverse so a stale value never passes
   assign pinsIn.ioIn = rdN ? ~lastOut : lastOut;
   assign pinsIn.rb   = ~busy;
endmodule : nand_flash_model
`default_nettype wire

// ==== bench/nand_host_ctrl_tb_top.sv ====
// Self-checking bench of the flash host with random addresses and data
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_defines.svh"
module nand_host_ctrl_tb_top
   import nand_host_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, rnd;
   logic        pready, pslverr, er, x16Mode = 1'b0;
   pinsOut_s    pins;
   pinsIn_s     pinsIn;
   int          n_errors = 0, n_checks = 0, cycles = 0, nc;
   logic [7:0]  cmds[7] = '{8'h00, 8'h01, 8'h50, 8'h90, 8'h80, 8'h60, 8'h8a};

   always #12.5 clk_sys = ~clk_sys;

   nand_host_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .pinsIn(pinsIn));
   nand_flash_model flash (.x16(x16Mode), .pins(pins), .pinsIn(pinsIn));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int nAddr(input logic [7:0] c);
      nAddr = (c == 8'h60) ? 2 : (c == 8'h90) ? 1 : 3;
   endfunction : nAddr

   function automatic logic [7:0] expAddr(input logic [7:0] c, input logic [31:0] a, input int i);
      if (c == 8'h60) expAddr = (i == 0) ? {a[16:14], 5'h00} : a[24:17];
      else if (i == 0) expAddr = (c == 8'h50) ? {4'h0, a[3:0]} : a[7:0];
      else expAddr = (i == 1) ? a[16:9] : a[24:17];
   endfunction : expAddr

   function automatic logic [31:0] expData(input logic [7:0] c, input logic [31:0] a,
                                           input int i, input logic x);
      logic [9:0] k;
      logic [7:0] lo;
      k = (c == 8'h50) ? (x ? 10'd256 + {7'h0, a[2:0]} : 10'd512 + {6'h0, a[3:0]})
                       : {1'b0, c == 8'h01, a[7:0]};
      k = k + 10'(i);
      lo = k[7:0] ^ {k[9:8], k[9:8], 4'hc};
      expData = x ? {16'h0, ~k[7:0], lo} : {24'h0, lo};
   endfunction : expData

   task automatic print_verdict();
      if (n_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (exp !== got) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic waitStat(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, `NH_REG_STATUS, 32'h0);
         n++;
      end while (rd[b] !== v && n < 200);
      chk("status wait", {31'h0, v}, {31'h0, rd[b]});
   endtask : waitStat

   task automatic op(input logic [1:0] o, input logic [7:0] b);
      apb(1'b1, `NH_REG_CTRL, {22'h0, o, b});
      waitStat(`NH_ST_BUSY, 1'b0);
   endtask : op

   task automatic refused(input logic [1:0] o, input logic [7:0] b);
      nc = flash.cmdLog.size();
      op(o, b);
      chk("cmd count", nc, flash.cmdLog.size());
      apb(1'b0, `NH_REG_STATUS, 32'h0);
      chk("err bit", 32'h1, {31'h0, rd[`NH_ST_ERR]});
      apb(1'b1, `NH_REG_STATUS, 32'h4);
   endtask : refused

   task automatic readTwo(input logic [7:0] c, input logic x);
      waitStat(`NH_ST_READY, 1'b1);
      for (int i = 0; i < 2; i++) begin
         op(2'd2, 8'h00);
         apb(1'b0, `NH_REG_DATA, 32'h0);
         chk("read data", expData(c, rnd, i, x), rd);
      end
   endtask : readTwo

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         print_verdict();
      end
   end

   initial begin
      rnd = 32'h9017;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      waitStat(`NH_ST_READY, 1'b1);
      apb(1'b0, `NH_REG_CONFIG, 32'h0);
      chk("config reset", 32'h2, rd);
      chk("write protect pin", 32'h1, {31'h0, pins.wpN});
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      foreach (cmds[j]) begin
         rnd = lfsr(rnd);
         waitStat(`NH_ST_READY, 1'b1);
         apb(1'b1, `NH_REG_ADDR, {7'h0, rnd[24:0]});
         flash.addrLog.delete();
         op(2'd0, cmds[j]);
         chk("command byte", cmds[j], flash.cmdLog[$]);
         chk("addr count", nAddr(cmds[j]), flash.addrLog.size());
         for (int i = 0; i < nAddr(cmds[j]); i++)
            chk("addr byte", expAddr(cmds[j], rnd, i), flash.addrLog[i]);
         if (cmds[j] inside {8'h00, 8'h01, 8'h50}) begin
            readTwo(cmds[j], 1'b0);
         end
         if (cmds[j] == 8'h80) begin
            // Second data write meets a busy engine and waits on pready
            apb(1'b1, `NH_REG_CTRL, {22'h0, 2'd1, rnd[31:24]});
            op(2'd1, rnd[23:16]);
            chk("prog data", {24'h0, rnd[31:24]}, {16'h0, flash.dataLog[$-1]});
            chk("prog data", {24'h0, rnd[23:16]}, {16'h0, flash.dataLog[$]});
            op(2'd0, 8'h10);
            chk("prog confirm", 32'h10, flash.cmdLog[$]);
         end
         if (cmds[j] == 8'h60) begin
            op(2'd0, 8'hd0);
            chk("erase confirm", 32'hd0, flash.cmdLog[$]);
            waitStat(`NH_ST_READY, 1'b0);
            refused(2'd0, 8'h90);
            op(2'd0, 8'h70);
            chk("status cmd", 32'h70, flash.cmdLog[$]);
         end
      end
      waitStat(`NH_ST_READY, 1'b1);
      refused(2'd0, 8'h33);
      refused(2'd3, 8'h00);
      op(2'd0, 8'hff);
      chk("reset cmd", 32'hff, flash.cmdLog[$]);
      apb(1'b1, `NH_REG_CONFIG, 32'h7);
      x16Mode = 1'b1;
      refused(2'd0, 8'h01);
      chk("chip select hold", 32'h0, {31'h0, pins.ceN});
      rnd = lfsr(rnd);
      apb(1'b1, `NH_REG_ADDR, {7'h0, rnd[24:0]});
      op(2'd0, 8'h50);
      readTwo(8'h50, 1'b1);
      chk("upper io", 32'h0, flash.upperHigh);
      chk("strobe select", 32'h0, flash.ceViolations);
      print_verdict();
   end
endmodule : nand_host_ctrl_tb_top
`default_nettype wire

// ==== hw/nand_host_ctrl.sv ====
// APB-controlled host that drives the command, address and data pins of a page flash
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_defines.svh"
module nand_host_ctrl
   import nand_host_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  pinsOut_s    pins,
   input  wire pinsIn_s     pinsIn
);
   engState_e   state_ff;
   logic [3:0]  cnt_ff;
   logic [15:0] busVal_ff;
   logic        busCle_ff;
   logic        busAle_ff;
   logic [1:0]  addrIdx_ff;
   logic [1:0]  addrLeft_ff;
   logic [7:0]  cmdReg_ff;
   logic [15:0] rdData_ff;
   logic [24:0] addr_ff;
   logic        errFlag_ff;
   logic        cfgX16_ff;
   logic        cfgWpN_ff;
   logic        cfgCeHold_ff;
   pinsIn_s     syncIn;
   logic        devReady;
   logic        access;
   logic        hit;
   logic        wrCtrl;
   logic        wrEn;
   logic        req;
   logic        reqCmd;
   hostOp_e     reqOp;
   logic [7:0]  reqByte;
   logic        cmdOk;
   logic        startCmd;
   logic        rejectCmd;
   logic        engIdle;
   logic        strobing;
   logic [7:0]  addrByte;
   logic [7:0]  nxt_col;

   nand_pin_sync #(
      .WIDTH (17)
   ) uSync (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .pinIn   (pinsIn),
      .pinOut  (syncIn)
   );

   assign devReady = syncIn.rb;
   assign engIdle  = (state_ff == ST_IDLE);
   assign strobing = (state_ff == ST_SETUP) || (state_ff == ST_WLOW) || (state_ff == ST_WHIGH);

   // APB slave
   assign access  = psel && penable;
   assign wrCtrl  = access && pwrite && (paddr == `NH_REG_CTRL);
   assign pready  = !(wrCtrl && !engIdle);
   assign wrEn    = access && pwrite && pready;
   assign pslverr = access && !hit;
   assign req     = wrCtrl && engIdle;
   assign reqOp   = hostOp_e'(pwdata[`NH_CTRL_OP_MSB:`NH_CTRL_OP_LSB]);
   assign reqByte = pwdata[`NH_CTRL_BYTE_MSB:0];
   assign reqCmd  = req && (reqOp == OP_CMD);

   // Only defined bytes; 01h only on x8; busy part takes reset and status
   assign cmdOk = isLegalCmd(reqByte) &&
                  !(cfgX16_ff && reqByte == `NH_CMD_READ1B) &&
                  (devReady || reqByte == `NH_CMD_RESET || reqByte == `NH_CMD_STATUS);
   assign startCmd  = reqCmd && cmdOk;
   assign rejectCmd = (reqCmd && !cmdOk) || (req && reqOp == OP_BAD);

   always_comb begin
      hit    = 1'b1;
      prdata = 32'h0000_0000;
      if (paddr == `NH_REG_CTRL) begin
         prdata = {24'h00_0000, cmdReg_ff};
      end else if (paddr == `NH_REG_ADDR) begin
         prdata = {7'h00, addr_ff};
      end else if (paddr == `NH_REG_DATA) begin
         prdata = {16'h0000, rdData_ff};
      end else if (paddr == `NH_REG_STATUS) begin
         prdata = {29'h0000_0000, errFlag_ff, devReady, !engIdle};
      end else if (paddr == `NH_REG_CONFIG) begin
         prdata = {29'h0000_0000, cfgCeHold_ff, cfgWpN_ff, cfgX16_ff};
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cfgX16_ff    <= 1'b0;
         cfgWpN_ff    <= `NH_CFG_WPN_RST;
         cfgCeHold_ff <= 1'b0;
         addr_ff      <= 25'h000_0000;
      end else if (wrEn && paddr == `NH_REG_CONFIG) begin
         cfgX16_ff    <= pwdata[`NH_CFG_X16];
         cfgWpN_ff    <= pwdata[`NH_CFG_WPN];
         cfgCeHold_ff <= pwdata[`NH_CFG_CEHOLD];
      end else if (wrEn && paddr == `NH_REG_ADDR) begin
         addr_ff <= pwdata[24:0];
      end
   end

   // Sticky refusal flag, set wins over clear
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         errFlag_ff <= 1'b0;
      end else if (rejectCmd) begin
         errFlag_ff <= 1'b1;
      end else if (wrEn && paddr == `NH_REG_STATUS && pwdata[`NH_ST_ERR]) begin
         errFlag_ff <= 1'b0;
      end
   end

   // Column byte: bit 8 is never sent, the read opcode selects the half
   always_comb begin
      nxt_col = addr_ff[7:0];
      if (cmdReg_ff == `NH_CMD_READ2) begin
         nxt_col = addr_ff[7:0] & (cfgX16_ff ? `NH_SPARE_X16_MASK : `NH_SPARE_X8_MASK);
      end
   end

   always_comb begin
      case (addrIdx_ff)
         2'd0:    addrByte = nxt_col;
         2'd1:    addrByte = (cmdReg_ff == `NH_CMD_ERASE) ?
                             (addr_ff[16:9] & ~`NH_PAGE_IN_BLK) : addr_ff[16:9];
         2'd2:    addrByte = addr_ff[24:17];
         default: addrByte = 8'h00;
      endcase
   end

   // Bus engine: one strobe per command, address or data item
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff    <= ST_IDLE;
         cnt_ff      <= 4'h0;
         busVal_ff   <= 16'h0000;
         busCle_ff   <= 1'b0;
         busAle_ff   <= 1'b0;
         addrIdx_ff  <= 2'd0;
         addrLeft_ff <= 2'd0;
         cmdReg_ff   <= 8'h00;
         rdData_ff   <= 16'h0000;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (startCmd) begin
                  busVal_ff   <= {8'h00, reqByte};
                  busCle_ff   <= 1'b1;
                  busAle_ff   <= 1'b0;
                  cmdReg_ff   <= reqByte;
                  addrLeft_ff <= addrCycles(reqByte);
                  addrIdx_ff  <= (reqByte == `NH_CMD_ERASE) ? 2'd1 : 2'd0;
                  state_ff    <= ST_SETUP;
               end else if (req && reqOp == OP_WDATA) begin
                  busVal_ff   <= cfgX16_ff ? pwdata[15:0] : {8'h00, pwdata[7:0]};
                  busCle_ff   <= 1'b0;
                  busAle_ff   <= 1'b0;
                  addrLeft_ff <= 2'd0;
                  state_ff    <= ST_SETUP;
               end else if (req && reqOp == OP_RDATA) begin
                  cnt_ff   <= 4'(`NH_RD_CYC - 1);
                  state_ff <= ST_RLOW;
               end
            end
            ST_SETUP: begin
               cnt_ff   <= 4'(`NH_WP_CYC - 1);
               state_ff <= ST_WLOW;
            end
            ST_WLOW: begin
               if (cnt_ff == 4'h0) begin
                  cnt_ff   <= 4'(`NH_WH_CYC - 1);
                  state_ff <= ST_WHIGH;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            ST_WHIGH: begin
               if (cnt_ff != 4'h0) begin
                  cnt_ff <= cnt_ff - 4'h1;
               end else if (addrLeft_ff != 2'd0) begin
                  busVal_ff   <= {8'h00, addrByte};
                  busCle_ff   <= 1'b0;
                  busAle_ff   <= 1'b1;
                  addrIdx_ff  <= addrIdx_ff + 2'd1;
                  addrLeft_ff <= addrLeft_ff - 2'd1;
                  state_ff    <= ST_SETUP;
               end else begin
                  busCle_ff <= 1'b0;
                  busAle_ff <= 1'b0;
                  state_ff  <= ST_IDLE;
               end
            end
            ST_RLOW: begin
               if (cnt_ff == 4'h0) begin
                  rdData_ff <= cfgX16_ff ? syncIn.ioIn : {8'h00, syncIn.ioIn[7:0]};
                  cnt_ff    <= 4'(`NH_RH_CYC - 1);
                  state_ff  <= ST_RHIGH;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            ST_RHIGH: begin
               if (cnt_ff == 4'h0) begin
                  state_ff <= ST_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Pin drivers, registered from engine state and config register
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pins <= '{ceN: 1'b1, cle: 1'b0, ale: 1'b0, weN: 1'b1, read_strobe_n: 1'b1,
                   wpN: 1'b0, ioOut: 16'h0000, ioOeN: 1'b1};
      end else begin
         pins.ceN           <= !(cfgCeHold_ff || !engIdle);
         pins.cle           <= strobing && busCle_ff;
         pins.ale           <= strobing && busAle_ff;
         pins.weN           <= (state_ff != ST_WLOW);
         pins.read_strobe_n <= (state_ff != ST_RLOW);
         pins.wpN           <= cfgWpN_ff;
         pins.ioOut         <= busVal_ff;
         pins.ioOeN         <= !strobing;
      end
   end

   // Checking helpers
   logic       weNPrev_ff;
   logic [2:0] aleCnt_ff;
   logic       seqCmd_ff;
   logic       weRise;
   assign weRise = pins.weN && !weNPrev_ff;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         weNPrev_ff <= 1'b1;
         aleCnt_ff  <= 3'd0;
         seqCmd_ff  <= 1'b0;
      end else begin
         weNPrev_ff <= pins.weN;
         if (weRise && pins.cle) begin
            aleCnt_ff <= 3'd0;
         end else if (weRise && pins.ale) begin
            aleCnt_ff <= aleCnt_ff + 3'd1;
         end
         if (startCmd) begin
            seqCmd_ff <= 1'b1;
         end else if (req) begin
            seqCmd_ff <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence seqReadPulse;
      !pins.read_strobe_n [*6] ##1 pins.read_strobe_n;
   endsequence

   sequence seqRefused;
      errFlag_ff && engIdle;
   endsequence

   AST_WE_CE: assert property (!pins.weN |-> !pins.ceN)
      else $error("write strobe low while chip deselected");
   AST_WE_PULSE: assert property ($fell(pins.weN) |=> pins.weN ##1 pins.weN)
      else $error("write strobe pulse has wrong shape");
   AST_LATCH_EXCL: assert property (!(pins.cle && pins.ale))
      else $error("command and address latch both high");
   AST_UPPER_LOW: assert property ((pins.cle || pins.ale) && !pins.ioOeN |-> pins.ioOut[15:8] == 8'h00)
      else $error("upper I/O byte not low in command or address cycle");
   AST_ROW_LOW: assert property (weRise && pins.ale && aleCnt_ff == 3'd1 && cmdReg_ff != `NH_CMD_ERASE |-> pins.ioOut[7:0] == addr_ff[16:9])
      else $error("second address cycle is not low row");
   AST_ERASE_BLOCK: assert property (weRise && pins.ale && aleCnt_ff == 3'd0 && cmdReg_ff == `NH_CMD_ERASE |-> pins.ioOut[4:0] == 5'h00)
      else $error("erase row carries page bits");
   AST_SPARE_COL: assert property (weRise && pins.ale && aleCnt_ff == 3'd0 && cmdReg_ff == `NH_CMD_READ2 |-> pins.ioOut[7:4] == 4'h0)
      else $error("spare read column outside spare area");
   AST_PAGE_ADDR3: assert property ($rose(engIdle) && seqCmd_ff && (cmdReg_ff == `NH_CMD_PROG || cmdReg_ff == `NH_CMD_READ1) |=> aleCnt_ff == 3'd3)
      else $error("page command without three address cycles");
   AST_ERASE_ADDR2: assert property ($rose(engIdle) && seqCmd_ff && cmdReg_ff == `NH_CMD_ERASE |=> aleCnt_ff == 3'd2)
      else $error("erase without exactly two row cycles");
   AST_NO_EXTRA: assert property ($rose(engIdle) && seqCmd_ff && cmdReg_ff == `NH_CMD_STATUS |=> aleCnt_ff == 3'd0)
      else $error("address cycles after status command");
   AST_BUSY_REFUSE: assert property (reqCmd && !devReady && reqByte != `NH_CMD_RESET && reqByte != `NH_CMD_STATUS |=> seqRefused)
      else $error("command issued to busy device");
   AST_UNDEF_REFUSE: assert property (reqCmd && !isLegalCmd(reqByte) |=> seqRefused)
      else $error("undefined command byte issued");
   AST_X16_HALF: assert property (reqCmd && cfgX16_ff && reqByte == `NH_CMD_READ1B |=> seqRefused)
      else $error("second-half read issued in x16 mode");
   AST_READ_PULSE: assert property ($fell(pins.read_strobe_n) |-> seqReadPulse)
      else $error("read strobe pulse has wrong length");
   AST_READ_NODRIVE: assert property (!pins.read_strobe_n |-> pins.ioOeN)
      else $error("host drives I/O while reading");

endmodule : nand_host_ctrl
`default_nettype wire

// ==== hw/nand_host_defines.svh ====
// Offsets, fields, command codes, geometry and timing of the flash host
`ifndef NAND_HOST_DEFINES_SVH
`define NAND_HOST_DEFINES_SVH

// Host register offsets (byte addresses, one word each)
`define NH_REG_CTRL       8'h00
`define NH_REG_ADDR       8'h04
`define NH_REG_DATA       8'h08
`define NH_REG_STATUS     8'h0c
`define NH_REG_CONFIG     8'h10

// Control word fields
`define NH_CTRL_BYTE_MSB  7
`define NH_CTRL_OP_LSB    8
`define NH_CTRL_OP_MSB    9
// Status and config bit positions
`define NH_ST_BUSY        0
`define NH_ST_READY       1
`define NH_ST_ERR         2
`define NH_CFG_X16        0
`define NH_CFG_WPN        1
`define NH_CFG_CEHOLD     2
// Reset values
`define NH_CFG_WPN_RST    1'b1

// Command set
`define NH_CMD_READ1      8'h00
`define NH_CMD_READ1B     8'h01
`define NH_CMD_READ2      8'h50
`define NH_CMD_READID     8'h90
`define NH_CMD_RESET      8'hff
`define NH_CMD_PROG       8'h80
`define NH_CMD_PROG_GO    8'h10
`define NH_CMD_COPY_GO    8'h8a
`define NH_CMD_ERASE      8'h60
`define NH_CMD_ERASE_GO   8'hd0
`define NH_CMD_STATUS     8'h70

// Geometry
`define NH_PAGES          65536
`define NH_BLOCKS         2048
`define NH_PAGE_IN_BLK    8'h1f
`define NH_SPARE_X8_MASK  8'h0f
`define NH_SPARE_X16_MASK 8'h07

// Timing
`define NH_CLK_NS         25
`define NH_T_WP_NS        25
`define NH_T_WH_NS        15
`define NH_T_REA_NS       35
`define NH_T_RH_NS        15
`define NH_SYNC_STAGES    3
`define NH_WP_CYC  ((`NH_T_WP_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_WH_CYC  ((`NH_T_WH_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_RH_CYC  ((`NH_T_RH_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_RD_CYC  (((`NH_T_REA_NS + `NH_CLK_NS - 1) / `NH_CLK_NS) + `NH_SYNC_STAGES + 1)

`endif

// ==== hw/nand_host_pkg.sv ====
// Types and helper functions of the flash host
`default_nettype none
`include "nand_host_defines.svh"
package nand_host_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_WLOW  = 3'b010,
      ST_WHIGH = 3'b011,
      ST_RLOW  = 3'b100,
      ST_RHIGH = 3'b101
   } engState_e;

   typedef enum logic [1:0] {
      OP_CMD   = 2'b00,
      OP_WDATA = 2'b01,
      OP_RDATA = 2'b10,
      OP_BAD   = 2'b11
   } hostOp_e;

   typedef struct packed {
      logic        ceN;
      logic        cle;
      logic        ale;
      logic        weN;
      logic        read_strobe_n;
      logic        wpN;
      logic [15:0] ioOut;
      logic        ioOeN;
   } pinsOut_s;

   typedef struct packed {
      logic        rb;
      logic [15:0] ioIn;
   } pinsIn_s;

   function automatic logic isLegalCmd(input logic [7:0] c);
      isLegalCmd = (c == `NH_CMD_READ1) || (c == `NH_CMD_READ1B) || (c == `NH_CMD_READ2) ||
                   (c == `NH_CMD_READID) || (c == `NH_CMD_RESET) || (c == `NH_CMD_PROG) ||
                   (c == `NH_CMD_PROG_GO) || (c == `NH_CMD_COPY_GO) ||
                   (c == `NH_CMD_ERASE) || (c == `NH_CMD_ERASE_GO) || (c == `NH_CMD_STATUS);
   endfunction : isLegalCmd

   // Address cycles that follow a command byte
   function automatic logic [1:0] addrCycles(input logic [7:0] c);
      if (c == `NH_CMD_READ1 || c == `NH_CMD_READ1B || c == `NH_CMD_READ2 ||
          c == `NH_CMD_PROG || c == `NH_CMD_COPY_GO)
         addrCycles = 2'd3;
      else if (c == `NH_CMD_ERASE)
         addrCycles = 2'd2;
      else if (c == `NH_CMD_READID)
         addrCycles = 2'd1;
      else
         addrCycles = 2'd0;
   endfunction : addrCycles

endpackage : nand_host_pkg
`default_nettype wire

// ==== hw/nand_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module nand_pin_sync #(
   parameter int WIDTH = 17
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] pinIn,
   output var  logic [WIDTH-1:0] pinOut
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : gBit
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               s1_ff[i]  <= 1'b0;
               s2_ff[i]  <= 1'b0;
               s3_ff[i]  <= 1'b0;
               pinOut[i] <= 1'b0;
            end else begin
               s1_ff[i] <= pinIn[i];
               s2_ff[i] <= s1_ff[i];
               s3_ff[i] <= s2_ff[i];
               // A change counts once stages two and three agree
               if (s2_ff[i] == s3_ff[i]) begin
                  pinOut[i] <= s3_ff[i];
               end
            end
         end
      end
   endgenerate
endmodule : nand_pin_sync
`default_nettype wire
